//--- gcsr_general_control.sv
/*
 * General control and startup register group: status read-back,
 * self-clearing calibration and initialisation triggers, read edge select
 * and multi-buffer alignment arming.
 * Assumes a serial port front end on ref_clk that presents single-cycle
 * read and write strobes; status and done inputs arrive from analog
 * blocks outside this clock domain and are synchronised here.
 */
`include "gcsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module gcsr_general_control (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire gcsr_pkg::gcsr_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic startup_done_in,
	input wire gcsr_pkg::gcsr_dcal_in_t dcal_in,
	input wire logic bias_cal_done_in,
	input wire logic [5:0] precision_bias_level_in,
	input wire logic sysref_in,
	output logic clk_path_init,
	output logic delay_ref_cal_start,
	output logic bias_cal_start,
	output logic bias_cal_busy,
	output logic read_edge_select,
	output logic multi_buffer_align_en,
	output logic align_start
);

	// Index of each asynchronous input in the synchroniser bank.
	localparam int SYN_STARTUP = 0;
	localparam int SYN_DCAL = 1;
	localparam int SYN_BIAS = 2;
	localparam int SYN_SYSREF = 3;
	localparam int SYN_N = 4;

	// Match a register offset against a write strobe.
	function automatic logic wr_hit(input gcsr_pkg::gcsr_reg_req_t r,
		input logic [7:0] off);
		wr_hit = r.wr && (r.addr == off);
	endfunction

	logic [SYN_N-1:0] async_in;
	logic [SYN_N-1:0] syn1;
	logic [SYN_N-1:0] syn2;
	logic [SYN_N-1:0] syn3;
	logic [SYN_N-1:0] flt;
	logic [SYN_N-1:0] flt_d;
	logic [SYN_N-1:0] rise;
	logic [14:0] dcal_result;
	logic [5:0] precision_bias_level;
	gcsr_pkg::gcsr_bias_state_t bias_state;
	gcsr_pkg::gcsr_bias_state_t next_bias_state;
	wire wr_clk_init;
	wire wr_dcal;
	wire wr_bias;
	wire wr_align;
	wire trig_bit;
	wire [7:0] next_rdata;

	assign async_in = {sysref_in, bias_cal_done_in, dcal_in.done,
		startup_done_in};

	// Three-stage synchronisers; a level is accepted only once stages two
	// and three agree, which filters a single metastable resolution.
	genvar g;
	generate
		for (g = 0; g < SYN_N; g++)
		begin : g_sync
			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					syn1[g] <= 1'b0;
					syn2[g] <= 1'b0;
					syn3[g] <= 1'b0;
					flt[g] <= 1'b0;
					flt_d[g] <= 1'b0;
				end
				else
				begin
					syn1[g] <= async_in[g];
					syn2[g] <= syn1[g];
					syn3[g] <= syn2[g];
					flt[g] <= (syn2[g] == syn3[g]) ? syn3[g] : flt[g];
					flt_d[g] <= flt[g];
				end
			end
			assign rise[g] = flt[g] & ~flt_d[g];
		end
	endgenerate

	// Write decode; only the documented bit of each trigger register acts.
	assign trig_bit = reg_req.wdata[`GCSR_BIT_TRIGGER];
	assign wr_clk_init = wr_hit(reg_req, `GCSR_OFF_CLK_INIT) && trig_bit;
	assign wr_dcal = wr_hit(reg_req, `GCSR_OFF_DCAL_TRIG) && trig_bit;
	assign wr_bias = wr_hit(reg_req, `GCSR_OFF_BIAS_TRIG) && trig_bit;
	assign wr_align = wr_hit(reg_req, `GCSR_OFF_ALIGN_EDGE);

	// Trigger pulses last one cycle; only the bias trigger bit reads as 1, while the sequencer is busy.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clk_path_init <= 1'b0;
			delay_ref_cal_start <= 1'b0;
			bias_cal_start <= 1'b0;
		end
		else
		begin
			clk_path_init <= wr_clk_init;
			delay_ref_cal_start <= wr_dcal;
			bias_cal_start <= wr_bias && !bias_cal_busy;
		end
	end

	// Bias trigger stays set until the engine reports done; a new request
	// in the done cycle wins and keeps the sequencer busy.
	always_comb
	begin
		case (bias_state)
			gcsr_pkg::GCSR_BIAS_IDLE:
				next_bias_state = wr_bias ? gcsr_pkg::GCSR_BIAS_BUSY
					: gcsr_pkg::GCSR_BIAS_IDLE;
			gcsr_pkg::GCSR_BIAS_BUSY:
				next_bias_state = (rise[SYN_BIAS] && !wr_bias)
					? gcsr_pkg::GCSR_BIAS_IDLE : gcsr_pkg::GCSR_BIAS_BUSY;
			default:
				next_bias_state = gcsr_pkg::GCSR_BIAS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			bias_state <= gcsr_pkg::GCSR_BIAS_IDLE;
		else
			bias_state <= next_bias_state;
	end

	assign bias_cal_busy = (bias_state == gcsr_pkg::GCSR_BIAS_BUSY);

	// Calibration results are captured on the synchronised done edge; the
	// engines must hold their result buses stable while done is high.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dcal_result <= `GCSR_RST_DCAL_RESULT;
			precision_bias_level <= `GCSR_RST_PRECISION_BIAS_LEVEL;
		end
		else
		begin
			if (rise[SYN_DCAL])
				dcal_result <= dcal_in.result;
			if (rise[SYN_BIAS])
				precision_bias_level <= precision_bias_level_in;
		end
	end

	// Control bits; a sysref rise clears the arm bit unless a write of 1
	// lands in the same cycle, so a fresh arm is never lost.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			read_edge_select <= `GCSR_RST_READ_EDGE;
			multi_buffer_align_en <= `GCSR_RST_ALIGN_EN;
			align_start <= 1'b0;
		end
		else
		begin
			if (wr_align)
				read_edge_select <= reg_req.wdata[`GCSR_BIT_READ_EDGE];
			if (wr_align)
				multi_buffer_align_en <= reg_req.wdata[`GCSR_BIT_ALIGN_EN];
			else if (rise[SYN_SYSREF])
				multi_buffer_align_en <= 1'b0;
			align_start <= multi_buffer_align_en && rise[SYN_SYSREF];
		end
	end

	// Read mux; reserved bits and write-only triggers read as zero, except
	// the bias trigger which shows its pending state.
	assign next_rdata =
		(reg_req.addr == `GCSR_OFF_DCAL_HIGH) ? {1'b0, dcal_result[14:8]} :
		(reg_req.addr == `GCSR_OFF_DCAL_LOW) ? dcal_result[7:0] :
		(reg_req.addr == `GCSR_OFF_STARTUP) ?
			{6'h00, flt[SYN_STARTUP], 1'b0} :
		(reg_req.addr == `GCSR_OFF_PRECISION_BIAS_LEVEL) ? {2'h0, precision_bias_level} :
		(reg_req.addr == `GCSR_OFF_BIAS_TRIG) ? {bias_cal_busy, 7'h00} :
		(reg_req.addr == `GCSR_OFF_ALIGN_EDGE) ?
			{multi_buffer_align_en, 6'h00, read_edge_select} :
		8'h00;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (reg_req.rd)
			reg_rdata <= next_rdata;
	end

	AST_CLK_INIT_PULSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wr_clk_init |=> clk_path_init ##1 !clk_path_init || wr_clk_init)
		else $error("clock path init pulse missing or too long");
	AST_DCAL_START: assert property (@(posedge ref_clk) disable iff (!arst_n)
		delay_ref_cal_start |-> $past(wr_dcal))
		else $error("delay calibration start without trigger write");
	AST_DCAL_REQ: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wr_dcal |=> delay_ref_cal_start)
		else $error("delay calibration trigger write lost");
	AST_DCAL_RESULT: assert property (@(posedge ref_clk) disable iff (!arst_n)
		rise[SYN_DCAL] |=> dcal_result == $past(dcal_in.result))
		else $error("delay calibration result not captured");
	AST_STARTUP_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_req.rd && reg_req.addr == `GCSR_OFF_STARTUP |=>
		reg_rdata == {6'h00, $past(flt[SYN_STARTUP]), 1'b0})
		else $error("startup done readback wrong");
	AST_BIAS_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
		bias_cal_busy && !rise[SYN_BIAS] |=> bias_cal_busy)
		else $error("bias trigger cleared before calibration done");
	AST_BIAS_SET: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wr_bias |=> bias_cal_busy)
		else $error("bias trigger write did not set busy");
	AST_READ_EDGE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wr_align |=> read_edge_select == $past(reg_req.wdata[0]))
		else $error("read edge select not updated");
	AST_ALIGN: assert property (@(posedge ref_clk) disable iff (!arst_n)
		multi_buffer_align_en && rise[SYN_SYSREF] && !wr_align |=>
		align_start && !multi_buffer_align_en)
		else $error("alignment not started or arm not cleared");
	AST_PRECISION_BIAS_LEVEL_RO: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wr_hit(reg_req, `GCSR_OFF_PRECISION_BIAS_LEVEL) && !rise[SYN_BIAS] |=> $stable(precision_bias_level))
		else $error("bias level changed by host write");
	AST_RESERVED: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_req.rd && reg_req.addr == `GCSR_OFF_DCAL_HIGH |=> !reg_rdata[7])
		else $error("reserved bit read as one");

	COV_BIAS_CYCLE: cover property (@(posedge ref_clk) disable iff (!arst_n)
		wr_bias ##[1:200] !bias_cal_busy);
	COV_ALIGN: cover property (@(posedge ref_clk) disable iff (!arst_n)
		align_start);
	COV_DCAL_DONE: cover property (@(posedge ref_clk) disable iff (!arst_n)
		delay_ref_cal_start ##[1:200] rise[SYN_DCAL]);

endmodule // gcsr_general_control

`default_nettype wire

//--- gcsr_general_control_tb_top.sv
/*
 * Self-checking testbench for the general control register group.
 * Assumes the params header and package are compiled first.
 */
`include "gcsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module gcsr_general_control_tb_top;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	gcsr_pkg::gcsr_reg_req_t reg_req;
	gcsr_pkg::gcsr_dcal_in_t dcal_in = '0;
	logic [7:0] reg_rdata;
	logic startup_done_in = 1'b0;
	logic bias_cal_done_in = 1'b0;
	logic [5:0] precision_bias_level_in = 6'h00;
	logic sysref_in = 1'b0;
	logic clk_path_init, delay_ref_cal_start, bias_cal_start, bias_cal_busy;
	logic read_edge_select, multi_buffer_align_en, align_start;
	int err_total = 0;
	int comparisons = 0;
	wire [1:0] evts = {align_start, ~bias_cal_busy};

	// The clock toggles each half period of 4 ns.
	always #4 ref_clk = ~ref_clk;

	gcsr_host_model i_host (.ref_clk(ref_clk), .rdata(reg_rdata),
		.req(reg_req));
	gcsr_general_control i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.reg_req(reg_req), .reg_rdata(reg_rdata),
		.startup_done_in(startup_done_in), .dcal_in(dcal_in),
		.bias_cal_done_in(bias_cal_done_in),
		.precision_bias_level_in(precision_bias_level_in),
		.sysref_in(sysref_in), .clk_path_init(clk_path_init),
		.delay_ref_cal_start(delay_ref_cal_start),
		.bias_cal_start(bias_cal_start), .bias_cal_busy(bias_cal_busy),
		.read_edge_select(read_edge_select),
		.multi_buffer_align_en(multi_buffer_align_en),
		.align_start(align_start));

	task automatic report_and_stop();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		i_host.access(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		i_host.access(1'b0, a, 8'h00, q);
		chk("reg_rdata", e, q);
	endtask

	// Synchronised events take several edges, so the wait is bounded.
	task automatic wait_evt(input int b);
		int n;
		n = 0;
		while (evts[b] !== 1'b1 && n < 20)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (evts[b] !== 1'b1)
		begin
			err_total++;
			$display("mismatch event %0d expected 1 seen 0", b);
			report_and_stop();
		end
	endtask

	task automatic t_startup();
		rd_chk(`GCSR_OFF_STARTUP, 8'h00);
		rd_chk(`GCSR_OFF_ALIGN_EDGE, 8'h00);
		startup_done_in = 1'b1;
		repeat (6) @(negedge ref_clk);
		rd_chk(`GCSR_OFF_STARTUP, 8'h02);
	endtask

	task automatic t_clk_init();
		wr(`GCSR_OFF_CLK_INIT, 8'h80);
		chk("clk_path_init", 8'h01, {7'h00, clk_path_init});
		@(negedge ref_clk);
		chk("clk_path_init", 8'h00, {7'h00, clk_path_init});
		wr(`GCSR_OFF_CLK_INIT, 8'h7f);
		chk("clk_path_init", 8'h00, {7'h00, clk_path_init});
		rd_chk(`GCSR_OFF_CLK_INIT, 8'h00);
	endtask

	task automatic t_dcal();
		dcal_in = {1'b0, 15'h5a3c};
		wr(`GCSR_OFF_DCAL_TRIG, 8'h80);
		chk("delay_ref_cal_start", 8'h01, {7'h00, delay_ref_cal_start});
		@(negedge ref_clk);
		chk("delay_ref_cal_start", 8'h00, {7'h00, delay_ref_cal_start});
		dcal_in.done = 1'b1;
		repeat (8) @(negedge ref_clk);
		rd_chk(`GCSR_OFF_DCAL_HIGH, 8'h5a);
		rd_chk(`GCSR_OFF_DCAL_LOW, 8'h3c);
		wr(`GCSR_OFF_DCAL_HIGH, 8'hff);
		rd_chk(`GCSR_OFF_DCAL_HIGH, 8'h5a);
	endtask

	task automatic t_bias();
		precision_bias_level_in = 6'h2b;
		wr(`GCSR_OFF_BIAS_TRIG, 8'h80);
		chk("bias_cal_start", 8'h01, {7'h00, bias_cal_start});
		rd_chk(`GCSR_OFF_BIAS_TRIG, 8'h80);
		bias_cal_done_in = 1'b1;
		wait_evt(0);
		rd_chk(`GCSR_OFF_PRECISION_BIAS_LEVEL, 8'h2b);
		wr(`GCSR_OFF_PRECISION_BIAS_LEVEL, 8'hff);
		rd_chk(`GCSR_OFF_PRECISION_BIAS_LEVEL, 8'h2b);
	endtask

	task automatic t_align();
		wr(`GCSR_OFF_ALIGN_EDGE, 8'hff);
		chk("read_edge_select", 8'h01, {7'h00, read_edge_select});
		rd_chk(`GCSR_OFF_ALIGN_EDGE, 8'h81);
		sysref_in = 1'b1;
		wait_evt(1);
		chk("align_en", 8'h00, {7'h00, multi_buffer_align_en});
		@(negedge ref_clk);
		chk("align_start", 8'h00, {7'h00, align_start});
		rd_chk(`GCSR_OFF_ALIGN_EDGE, 8'h01);
		sysref_in = 1'b0;
		repeat (6) @(negedge ref_clk);
		sysref_in = 1'b1;
		repeat (8)
		begin
			@(negedge ref_clk);
			chk("align_start", 8'h00, {7'h00, align_start});
		end
	endtask

	// A reset in mid-run must return the control bits to their defaults.
	task automatic t_reset();
		arst_n = 1'b0;
		@(negedge ref_clk);
		arst_n = 1'b1;
		chk("read_edge_select", 8'h00, {7'h00, read_edge_select});
		@(negedge ref_clk);
		rd_chk(`GCSR_OFF_ALIGN_EDGE, 8'h00);
	endtask

	// Reset stays low for ten cycles, then the scenarios run in turn.
	initial
	begin
		repeat (10) @(negedge ref_clk);
		arst_n = 1'b1;
		@(negedge ref_clk);
		t_startup();
		t_clk_init();
		t_dcal();
		t_bias();
		t_align();
		t_reset();
		report_and_stop();
	end
endmodule // gcsr_general_control_tb_top

`default_nettype wire

//--- gcsr_host_model.sv
/*
 * Host model: the serial configuration master seen through the port front
 * end, issuing single-cycle register read and write strobes.
 * Assumes its task is called from a process that drives on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module gcsr_host_model (
	input wire logic ref_clk,
	input wire logic [7:0] rdata,
	output var gcsr_pkg::gcsr_reg_req_t req
);
	initial req = '0;

	// Strobes stand for exactly one rising edge, as the front end does.
	// Read data is taken a half cycle after that edge, once it has settled.
	// A falling edge passes before each request, so a release and the next
	// request never land in one time step.
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge ref_clk);
		req = {w, ~w, a, d};
		@(posedge ref_clk);
		@(negedge ref_clk);
		q = rdata;
		req = '0;
	endtask
endmodule // gcsr_host_model

`default_nettype wire

//--- gcsr_params.svh
/*
 * Register offsets, field positions, reset values and synchroniser depth
 * for the general control and startup register group.
 * Assumes it is included by bare name from the design files.
 */
`ifndef GCSR_PARAMS_SVH
`define GCSR_PARAMS_SVH

`define GCSR_OFF_DCAL_HIGH 8'h6c
`define GCSR_OFF_DCAL_LOW 8'h6d
`define GCSR_OFF_STARTUP 8'h6e
`define GCSR_OFF_PRECISION_BIAS_LEVEL 8'h6f
`define GCSR_OFF_CLK_INIT 8'h70
`define GCSR_OFF_DCAL_TRIG 8'h71
`define GCSR_OFF_BIAS_TRIG 8'h72
`define GCSR_OFF_ALIGN_EDGE 8'h73

`define GCSR_BIT_STARTUP_DONE 1
`define GCSR_BIT_TRIGGER 7
`define GCSR_BIT_ALIGN_EN 7
`define GCSR_BIT_READ_EDGE 0

`define GCSR_RST_READ_EDGE 1'b0
`define GCSR_RST_ALIGN_EN 1'b0
`define GCSR_RST_DCAL_RESULT 15'h0000
`define GCSR_RST_PRECISION_BIAS_LEVEL 6'h00

`define GCSR_SYNC_DEPTH 3

`endif

//--- gcsr_pkg.sv
/*
 * Types shared by the general control and startup register group.
 * Assumes the params header is compiled alongside.
 */
`default_nettype none

package gcsr_pkg;

	// Register access request as delivered by the serial port front end.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gcsr_reg_req_t;

	// Result of the delay calibration block engine.
	typedef struct packed {
		logic done;
		logic [14:0] result;
	} gcsr_dcal_in_t;

	// Bias calibration sequencer states.
	typedef enum logic [1:0] {
		GCSR_BIAS_IDLE = 2'b01,
		GCSR_BIAS_BUSY = 2'b10
	} gcsr_bias_state_t;

endpackage

`default_nettype wire
